// *** rtl/ptc_pkg.sv ***
// constants, field layouts and types of the periodic tick counter
// assumes a 32-bit APB slave with one register of up to 8 bits per aligned word
package ptc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SC  = 8'h00;
  localparam logic [7:0] ADDR_CNT = 8'h04;
  localparam logic [7:0] ADDR_LIM = 8'h08;
  localparam logic [7:0] ADDR_EVT = 8'h0c;
  localparam logic [7:0] ADDR_MSK = 8'h10;

  // ----------------------------------------------------------------
  // field positions and values after reset
  // ----------------------------------------------------------------
  localparam int         FLAG_BIT  = 7;
  localparam int         SRC_LSB   = 5;
  localparam int         IRQEN_BIT = 4;
  localparam int         EVT_W     = 2;
  localparam int         EVT_RECFG = 0;
  localparam int         EVT_OVRUN = 1;
  localparam logic [7:0] SC_RST    = 8'h00;
  localparam logic [7:0] CNT_RST   = 8'h00;
  localparam logic [7:0] LIM_RST   = 8'h00;
  localparam logic [1:0] EVT_RST   = 2'h0;
  localparam int         PRE_W     = 18;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_LPO  = 2'b00,
    SRC_EXT  = 2'b01,
    SRC_INT  = 2'b10,
    SRC_INT2 = 2'b11
  } ptc_src_e;

  typedef struct packed {
    logic       matchFlag;
    ptc_src_e   sourceSelect;
    logic       matchIrqEnable;
    logic [3:0] dividerSelect;
  } ptc_ctrl_s;

  // divide-by values, code 0 means off
  localparam logic [PRE_W-1:0] DIV_BIN [16] = '{
    18'h0, 18'h8, 18'h20, 18'h40, 18'h80, 18'h100, 18'h200, 18'h400,
    18'h1, 18'h2, 18'h4, 18'ha, 18'h10, 18'h64, 18'h1f4, 18'h3e8};
  localparam logic [PRE_W-1:0] DIV_DEC [16] = '{
    18'h0, 18'h400, 18'h800, 18'h1000, 18'h2000, 18'h4000, 18'h8000,
    18'h10000, 18'h3e8, 18'h7d0, 18'h1388, 18'h2710, 18'h4e20,
    18'hc350, 18'h186a0, 18'h30d40};

  function automatic logic [PRE_W-1:0] divisor(input logic dec,
                                               input logic [3:0] code);
    return dec ? DIV_DEC[code] : DIV_BIN[code];
  endfunction : divisor

endpackage : ptc_pkg

// *** rtl/ptc_periodic_tick_counter.sv ***
// periodic tick counter: source select, prescaler, 8-bit counter, limit
// match flag and interrupt, behind an APB slave
// assumes the three tick sources arrive as asynchronous pins and are
// far slower than the 250 MHz clock
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - The match flag in bit 7 is set on the prescaler tick that finds the counter at the limit and stays set.
// - Writing 1 to the flag clears flag and its request; writing 0 leaves it alone.
// - Reset clears the flag, source select, interrupt enable and divider select.
// - Source select 00 takes the low power oscillator, 01 the external and 1x the internal clock.
// - Changing the source select clears prescaler and counter.
// - The interrupt request is high while the flag is set and its enable bit 4 is one.
// - With source bit 0 clear the divider codes give off, binary powers, then 1 to 1000.
// - With source bit 0 set the divider codes give off, 2^10 to 2^16, then 1000 to 2x10^5.
// - Changing the divider select clears prescaler and counter.
// - The count register reads the counter and ignores writes.
// - Any write to the limit register clears prescaler and counter.
// - At the limit the next advance returns the counter to zero and sets the flag.
// - With a zero limit the flag is set on every prescaler output edge.
// - Reset clears count and limit to zero.
// - With a nonzero divider the counter steps once per prescaler period.
module ptc_periodic_tick_counter (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // tick sources
  input  wire logic        lowPowerOscillator,
  input  wire logic        externalReferenceClock,
  input  wire logic        internalReferenceClock,
  // interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ptc_pkg::ptc_ctrl_s             ctrl_q;
  ptc_pkg::ptc_ctrl_s             ctrl_d;
  logic [7:0]                     count_q;
  logic [7:0]                     count_d;
  logic [7:0]                     limit_q;
  logic [ptc_pkg::PRE_W-1:0]      preCnt_q;
  logic [ptc_pkg::PRE_W-1:0]      preCnt_d;
  logic [ptc_pkg::EVT_W-1:0]      evt_q;
  logic [ptc_pkg::EVT_W-1:0]      evt_d;
  logic [ptc_pkg::EVT_W-1:0]      mask_q;
  logic [2:0]                     sync1_q;
  logic [2:0]                     sync2_q;
  logic [2:0]                     sync3_q;
  logic [2:0]                     level_q;
  logic [2:0]                     level_d;
  logic [2:0]                     rise_q;
  logic [31:0]                    prdata_q;
  logic                           pready_q;
  logic                           pslverr_q;
  logic                           irq_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire setupPh  = psel & ~penable;
  wire accessWr = psel & penable & pwrite & pready_q;
  wire hitSc    = paddr == ptc_pkg::ADDR_SC;
  wire hitCnt   = paddr == ptc_pkg::ADDR_CNT;
  wire hitLim   = paddr == ptc_pkg::ADDR_LIM;
  wire hitEvt   = paddr == ptc_pkg::ADDR_EVT;
  wire hitMsk   = paddr == ptc_pkg::ADDR_MSK;
  wire mapped   = hitSc | hitCnt | hitLim | hitEvt | hitMsk;
  wire wrSc     = accessWr & hitSc;
  wire wrCnt    = accessWr & hitCnt;
  wire wrLim    = accessWr & hitLim;
  wire wrEvt    = accessWr & hitEvt;
  wire wrMsk    = accessWr & hitMsk;

  wire [1:0] newSrc = pwdata[ptc_pkg::SRC_LSB+1:ptc_pkg::SRC_LSB];
  wire [3:0] newDiv = pwdata[3:0];

  wire srcChange = wrSc & (newSrc != ctrl_q.sourceSelect);
  wire divChange = wrSc & (newDiv != ctrl_q.dividerSelect);
  // any of these restarts the whole counting chain
  wire reconfig  = srcChange | divChange | wrLim;

  // read data is captured in the setup cycle, so the access phase
  // needs no wait state; count writes land nowhere
  wire [31:0] rdData =
    hitSc  ? {24'h0, ctrl_q} :
    hitCnt ? {24'h0, count_q} :
    hitLim ? {24'h0, limit_q} :
    hitEvt ? {30'h0, evt_q} :
    hitMsk ? {30'h0, mask_q} : 32'h0;

  // ----------------------------------------------------------------
  // source synchronisers
  // ----------------------------------------------------------------
  wire [2:0] srcPins = {internalReferenceClock, externalReferenceClock,
                        lowPowerOscillator};

  // a level is accepted only once stages two and three agree
  assign level_d = (sync2_q & sync3_q) | (level_q & (sync2_q | sync3_q));

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      level_q <= 3'h0;
      rise_q  <= 3'h0;
    end else begin
      sync1_q <= srcPins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
      rise_q  <= level_d & ~level_q;
    end
  end

  // ----------------------------------------------------------------
  // source select and prescaler
  // ----------------------------------------------------------------
  wire srcEdge =
    ctrl_q.sourceSelect[1] ? rise_q[2] :
    ctrl_q.sourceSelect[0] ? rise_q[1] : rise_q[0];

  wire [ptc_pkg::PRE_W-1:0] divValue =
    ptc_pkg::divisor(ctrl_q.sourceSelect[0], ctrl_q.dividerSelect);
  wire preRun  = ctrl_q.dividerSelect != 4'h0;
  // a tick coinciding with a restart is dropped with the old setting
  wire preTick = srcEdge & preRun & ~reconfig &
                 (preCnt_q == divValue - 18'h1);
  wire atLimit = count_q == limit_q;
  wire flagSet = preTick & atLimit;

  always_comb begin
    preCnt_d = preCnt_q;
    if (reconfig)
      preCnt_d = '0;
    else if (srcEdge & preRun)
      preCnt_d = preTick ? '0 : preCnt_q + 18'h1;
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_comb begin
    count_d = count_q;
    if (reconfig)
      count_d = 8'h00;
    else if (preTick)
      count_d = atLimit ? 8'h00 : count_q + 8'h01;
  end

  // ----------------------------------------------------------------
  // control register and flag
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (wrSc) begin
      ctrl_d.sourceSelect   = ptc_pkg::ptc_src_e'(newSrc);
      ctrl_d.matchIrqEnable = pwdata[ptc_pkg::IRQEN_BIT];
      ctrl_d.dividerSelect  = newDiv;
    end
    // a match in the clearing cycle survives the clear
    ctrl_d.matchFlag = flagSet |
      (ctrl_q.matchFlag & ~(wrSc & pwdata[ptc_pkg::FLAG_BIT]));
  end

  // ----------------------------------------------------------------
  // event status and mask
  // ----------------------------------------------------------------
  wire [ptc_pkg::EVT_W-1:0] evtSet = {flagSet & ctrl_q.matchFlag, reconfig};
  wire [ptc_pkg::EVT_W-1:0] evtClr =
    wrEvt ? pwdata[ptc_pkg::EVT_W-1:0] : '0;
  assign evt_d = evtSet | (evt_q & ~evtClr);

  // the request follows next-state values so it lines up with the flag
  wire irqNext = (ctrl_d.matchFlag & ctrl_d.matchIrqEnable) |
                 (|(evt_d & (wrMsk ? pwdata[ptc_pkg::EVT_W-1:0] : mask_q)));

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_q   <= ptc_pkg::ptc_ctrl_s'(ptc_pkg::SC_RST);
      count_q  <= ptc_pkg::CNT_RST;
      limit_q  <= ptc_pkg::LIM_RST;
      preCnt_q <= '0;
      evt_q    <= ptc_pkg::EVT_RST;
      mask_q   <= ptc_pkg::EVT_RST;
      irq_q    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      count_q  <= count_d;
      preCnt_q <= preCnt_d;
      evt_q    <= evt_d;
      irq_q    <= irqNext;
      if (wrLim)
        limit_q <= pwdata[7:0];
      if (wrMsk)
        mask_q <= pwdata[ptc_pkg::EVT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setupPh;
      pslverr_q <= setupPh & ~mapped;
      if (setupPh)
        prdata_q <= pwrite ? 32'h0 : rdData;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  flag_set_a: assert property (
    flagSet |=> ctrl_q.matchFlag)
    else $error("match flag not set after a match");

  flag_clear_a: assert property (
    wrSc && pwdata[ptc_pkg::FLAG_BIT] && !flagSet |=> !ctrl_q.matchFlag)
    else $error("writing one did not clear the match flag");

  flag_keep_a: assert property (
    wrSc && !pwdata[ptc_pkg::FLAG_BIT] && ctrl_q.matchFlag
      |=> ctrl_q.matchFlag)
    else $error("writing zero changed the match flag");

  src_restart_a: assert property (
    srcChange |=> count_q == 8'h00 && preCnt_q == '0)
    else $error("source change did not clear the counters");

  div_restart_a: assert property (
    divChange |=> count_q == 8'h00 && preCnt_q == '0)
    else $error("divider change did not clear the counters");

  lim_restart_a: assert property (
    wrLim |=> count_q == 8'h00 && limit_q == $past(pwdata[7:0]))
    else $error("limit write did not restart the counter");

  irq_level_a: assert property (
    ctrl_q.matchFlag && ctrl_q.matchIrqEnable |-> irq)
    else $error("enabled match flag without interrupt request");

  cnt_wrap_a: assert property (
    preTick && atLimit |=> count_q == 8'h00 && ctrl_q.matchFlag)
    else $error("counter did not wrap at the limit");

  cnt_step_a: assert property (
    preTick && !atLimit |=> count_q == $past(count_q) + 8'h01)
    else $error("counter did not step on a prescaler tick");

  cnt_hold_a: assert property (
    wrCnt && !preTick && !reconfig |=> $stable(count_q))
    else $error("write to count register changed the count");

  pre_off_a: assert property (
    ctrl_q.dividerSelect == 4'h0 |-> !preTick)
    else $error("prescaler ticked while off");

  edge_once_a: assert property (
    rise_q[0] |=> !rise_q[0])
    else $error("one source edge gave two pulses");

  sync_agree_a: assert property (
    $rose(level_q[0]) |-> $past(sync2_q[0]) && $past(sync3_q[0]))
    else $error("source level accepted before stages two and three agreed");

  // ----------------------------------------------------------------
  // assertions on reset, routing, the divider tables and the prescaler
  // ----------------------------------------------------------------
  // reset itself is watched, so this one must not be disabled by it
  reset_clear_a: assert property (
    disable iff (1'b0)
    !reset_n |=> ctrl_q == ptc_pkg::ptc_ctrl_s'(ptc_pkg::SC_RST) &&
                 count_q == 8'h00 && limit_q == 8'h00)
    else $error("reset left a register set");

  route_lpo_a: assert property (
    ctrl_q.sourceSelect == ptc_pkg::SRC_LPO |-> srcEdge == rise_q[0])
    else $error("select 00 did not route the low power oscillator");

  route_ext_a: assert property (
    ctrl_q.sourceSelect == ptc_pkg::SRC_EXT |-> srcEdge == rise_q[1])
    else $error("select 01 did not route the external clock");

  route_int_a: assert property (
    ctrl_q.sourceSelect[1] |-> srcEdge == rise_q[2])
    else $error("select 1x did not route the internal clock");

  bin_table_a: assert property (
    !ctrl_q.sourceSelect[0] && ctrl_q.dividerSelect == 4'h1 |-> divValue == 18'h8)
    else $error("binary table code 1 is not divide by eight");

  dec_table_a: assert property (
    ctrl_q.sourceSelect[0] && ctrl_q.dividerSelect == 4'h8 |-> divValue == 18'h3e8)
    else $error("decimal table code 8 is not divide by one thousand");

  pre_stop_a: assert property (
    ctrl_q.dividerSelect == 4'h0 && !reconfig |=> $stable(preCnt_q) && $stable(count_q))
    else $error("prescaler or counter moved while the divider was off");

  pre_wrap_a: assert property (
    preTick |=> preCnt_q == '0)
    else $error("prescaler did not restart after its output tick");

  lim_any_a: assert property (
    wrLim |=> preCnt_q == '0)
    else $error("limit write did not clear the prescaler");

  // ----------------------------------------------------------------
  // assertions on flag, request and bus answer
  // ----------------------------------------------------------------
  flag_hold_a: assert property (
    ctrl_q.matchFlag && !(wrSc && pwdata[ptc_pkg::FLAG_BIT]) |=> ctrl_q.matchFlag)
    else $error("match flag dropped without a clear");

  zero_lim_a: assert property (
    preTick && limit_q == 8'h00 |=> ctrl_q.matchFlag)
    else $error("zero limit did not set the flag on a prescaler tick");

  irq_off_a: assert property (
    !ctrl_q.matchIrqEnable && !(|(evt_q & mask_q)) |-> !irq)
    else $error("interrupt request without an enabled source");

  overrun_a: assert property (
    flagSet && ctrl_q.matchFlag |=> evt_q[ptc_pkg::EVT_OVRUN])
    else $error("match on a set flag did not record an overrun");

  cnt_noerr_a: assert property (
    wrCnt |-> !pslverr)
    else $error("count register write answered with an error");

  bus_ready_a: assert property (
    setupPh |=> pready)
    else $error("no ready in the cycle after a setup");

  unmapped_a: assert property (
    setupPh && !mapped |=> pslverr && pready && prdata == 32'h0)
    else $error("unmapped address not refused");

endmodule : ptc_periodic_tick_counter

// *** tb/periodic_tick_counter_tb.sv ***
// self-checking bench for the periodic tick counter, registers reached over apb
// assumes the design answers apb with its own pready and the tick pins are slow
`timescale 1ns/1ps

module periodic_tick_counter_tb;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clock   = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [2:0]  tickPin = 3'h0;
  wire  logic [31:0] prdata;
  wire  logic        pready;
  wire  logic        pslverr;
  wire  logic        irq;
  int          fails   = 0;
  int          checks  = 0;
  int          cycles  = 0;

  always #2 clock = ~clock;

  ptc_periodic_tick_counter dut (
    .clock                 (clock),
    .reset_n               (reset_n),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .lowPowerOscillator    (tickPin[0]),
    .externalReferenceClock(tickPin[1]),
    .internalReferenceClock(tickPin[2]),
    .irq                   (irq)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one apb transfer; the master waits at most 16 further cycles for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clock);
      n++;
    end
    chk("pready", 32'h1, {31'h0, pready});
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk($sformatf("register %h", a), {24'h0, exp}, r);
  endtask : rd

  task automatic irqIs(input logic exp);
    repeat (3) @(posedge clock);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask : irqIs

  // pins stay high and low well past the three-flop filter
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge clock);
      tickPin[idx] <= 1'b1;
      repeat (4) @(posedge clock);
      tickPin[idx] <= 1'b0;
      repeat (4) @(posedge clock);
    end
    repeat (8) @(posedge clock);
  endtask : pulse

  // ----------------------------------------------------------------
  // timeout
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      $display("[FAIL] timeout expected finish seen hang");
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    rd(ptc_pkg::ADDR_SC, 8'h00);
    rd(ptc_pkg::ADDR_CNT, 8'h00);
    rd(ptc_pkg::ADDR_LIM, 8'h00);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    // limit 2, lpo source, divide by 1, interrupt enabled
    wr(ptc_pkg::ADDR_LIM, 8'h02);
    wr(ptc_pkg::ADDR_SC, 8'h18);
    pulse(0, 2);
    rd(ptc_pkg::ADDR_CNT, 8'h02);
    rd(ptc_pkg::ADDR_SC, 8'h18);
    pulse(0, 1);
    rd(ptc_pkg::ADDR_CNT, 8'h00);
    rd(ptc_pkg::ADDR_SC, 8'h98);
    irqIs(1'b1);
    pulse(1, 2);
    rd(ptc_pkg::ADDR_CNT, 8'h00);
    pulse(0, 1);
    rd(ptc_pkg::ADDR_CNT, 8'h01);
    wr(ptc_pkg::ADDR_CNT, 8'h55);
    rd(ptc_pkg::ADDR_CNT, 8'h01);
    wr(ptc_pkg::ADDR_SC, 8'h18);
    rd(ptc_pkg::ADDR_SC, 8'h98);
    wr(ptc_pkg::ADDR_SC, 8'h98);
    rd(ptc_pkg::ADDR_SC, 8'h18);
    irqIs(1'b0);
    wr(ptc_pkg::ADDR_LIM, 8'h02);
    rd(ptc_pkg::ADDR_CNT, 8'h00);
    pulse(0, 1);
    wr(ptc_pkg::ADDR_SC, 8'h19);
    rd(ptc_pkg::ADDR_CNT, 8'h00);
    pulse(0, 1);
    rd(ptc_pkg::ADDR_CNT, 8'h00);
    pulse(0, 1);
    rd(ptc_pkg::ADDR_CNT, 8'h01);
    wr(ptc_pkg::ADDR_SC, 8'h58);
    rd(ptc_pkg::ADDR_CNT, 8'h00);
    pulse(0, 1);
    rd(ptc_pkg::ADDR_CNT, 8'h00);
    pulse(2, 1);
    rd(ptc_pkg::ADDR_CNT, 8'h01);
    // decimal table: external source, code 8 divides by one thousand
    wr(ptc_pkg::ADDR_SC, 8'h38);
    rd(ptc_pkg::ADDR_CNT, 8'h00);
    pulse(1, 999);
    rd(ptc_pkg::ADDR_CNT, 8'h00);
    pulse(1, 1);
    rd(ptc_pkg::ADDR_CNT, 8'h01);
    wr(ptc_pkg::ADDR_SC, 8'h30);
    pulse(1, 3);
    rd(ptc_pkg::ADDR_CNT, 8'h00);
    // zero limit, interrupt enable off
    wr(ptc_pkg::ADDR_SC, 8'h08);
    wr(ptc_pkg::ADDR_LIM, 8'h00);
    pulse(0, 1);
    rd(ptc_pkg::ADDR_SC, 8'h88);
    irqIs(1'b0);
    wr(ptc_pkg::ADDR_EVT, 8'h03);
    pulse(0, 1);
    rd(ptc_pkg::ADDR_SC, 8'h88);
    rd(ptc_pkg::ADDR_EVT, 8'h02);
    // event interrupt: raise, mask, unmask, clear
    wr(ptc_pkg::ADDR_EVT, 8'h03);
    rd(ptc_pkg::ADDR_EVT, 8'h00);
    wr(ptc_pkg::ADDR_MSK, 8'h01);
    wr(ptc_pkg::ADDR_LIM, 8'h00);
    irqIs(1'b1);
    rd(ptc_pkg::ADDR_EVT, 8'h01);
    wr(ptc_pkg::ADDR_MSK, 8'h00);
    irqIs(1'b0);
    wr(ptc_pkg::ADDR_MSK, 8'h01);
    irqIs(1'b1);
    wr(ptc_pkg::ADDR_EVT, 8'h01);
    irqIs(1'b0);
    rd(ptc_pkg::ADDR_MSK, 8'h01);
    test_done();
  end

endmodule : periodic_tick_counter_tb
